// File: mad_core_master.sv
`timescale 1ns/1ps
`default_nettype none

module mad_core_master
    import mad_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_xfer_ack,
    input wire logic i_xfer_err,
    input wire logic i_access_err,
    output logic o_req_valid,
    output var mad_req_t o_req
);
    int cyc;
    logic got_ack;
    logic got_eack;
    logic got_err;

    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
    end

    // ----------------------------------------
    // One access, held until acknowledged
    // ----------------------------------------
    // caller keeps accesses aligned
    task automatic access(input logic [31:0] a, input logic w, input logic s,
                          input logic [1:0] sz);
        o_req_valid = 1'b1;
        o_req = '{addr: a, write: w, supv: s, size: sz, wdata: a ^ 32'h5A5A_0F0F};
        cyc = 0;
        do begin
            @(posedge i_sys_clk);
            cyc++;
            got_ack = i_xfer_ack;
            got_eack = i_xfer_err;
            got_err = i_access_err;
        end while (!(got_ack || got_eack) && cyc < 400);
        @(negedge i_sys_clk);
        o_req_valid = 1'b0;
        // Released bus shows a changed pattern so stale values cannot pass
        o_req = ~o_req;
    endtask
endmodule

`default_nettype wire

// File: mad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mad_defines.svh"

module mad_decoder
    import mad_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_req_valid,
    input var mad_req_t i_req,
    input wire logic i_sup_prot,
    input wire logic [31:0] i_tgt_rdata,
    input wire logic i_per_w16,
    output var mad_sel_t o_sel,
    output logic [`MAD_EXT_AW-1:0] o_xaddr,
    output logic o_write,
    output logic [1:0] o_size,
    output logic [31:0] o_wdata,
    output logic [31:0] o_rdata,
    output logic o_transfer_ack,
    output logic o_transfer_error_ack,
    output logic o_access_err
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------

    function automatic mad_region_t fn_region(input logic [31:0] a);
        mad_region_t rg;
        rg = MAD_RG_RSV;
        if (a[31:20] == `MAD_ROM_MB) begin
            rg = MAD_RG_ROM;
        end else if (a[31:20] == `MAD_RAM_MB) begin
            rg = MAD_RG_RAM;
        end else if (a[31:21] == `MAD_PER_2MB) begin
            rg = MAD_RG_PER;
        end else if (a[31:24] >= `MAD_EXT_FIRST &&
                     a[31:24] < `MAD_EXT_FIRST + 8'(`MAD_EXT_NCS)) begin
            rg = MAD_RG_EXT;
        end
        return rg;
    endfunction

    function automatic logic fn_user_blocked(input logic sup, input logic prot);
        return prot && !sup;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    mad_region_t region;
    logic [20:0] per_off;
    logic [`MAD_NPER-1:0] per_hit;
    logic [`MAD_EXT_NCS-1:0] cs_hit;
    logic blocked;
    logic take;

    assign region = fn_region(i_req.addr);
    assign per_off = i_req.addr[20:0];
    assign blocked = fn_user_blocked(i_req.supv, i_sup_prot);

    genvar gi;
    generate
        for (gi = 0; gi < `MAD_NPER; gi++) begin : g_per
            if (gi < `MAD_N4K) begin : g_4k
                assign per_hit[gi] = region == MAD_RG_PER &&
                    per_off[20:16] == 5'h00 && per_off[15:12] == 4'(gi);
            end else begin : g_1k
                assign per_hit[gi] = region == MAD_RG_PER &&
                    per_off[20:12] == 9'(`MAD_N4K) &&
                    per_off[11:10] == 2'(gi - `MAD_N4K);
            end
        end
        for (gi = 0; gi < `MAD_EXT_NCS; gi++) begin : g_cs
            assign cs_hit[gi] = region == MAD_RG_EXT && i_req.addr[26:24] == 3'(gi);
        end
    endgenerate

    logic ok_nxt;
    logic wdog_nxt;
    mad_sel_t sel_nxt;
    logic [`MAD_EXT_AW-1:0] xaddr_nxt;

    always_comb begin
        ok_nxt = 1'b0;
        wdog_nxt = 1'b0;
        sel_nxt = '0;
        xaddr_nxt = '0;
        case (region)
            MAD_RG_ROM: begin
                ok_nxt = !i_req.write && !blocked;
                sel_nxt.rom = ok_nxt;
                xaddr_nxt = {8'h00, i_req.addr[`MAD_ROM_AW-1:0]};
            end
            MAD_RG_RAM: begin
                ok_nxt = !blocked;
                sel_nxt.ram = ok_nxt;
                xaddr_nxt = {11'h000, i_req.addr[`MAD_RAM_AW-1:0]};
            end
            MAD_RG_PER: begin
                if (per_hit != '0) begin
                    ok_nxt = i_req.write || !blocked;
                    sel_nxt.per = ok_nxt ? per_hit : '0;
                    xaddr_nxt = {10'h000, per_off[`MAD_PER_AW-1:0]};
                end else begin
                    wdog_nxt = 1'b1;
                end
            end
            MAD_RG_EXT: begin
                ok_nxt = 1'b1;
                sel_nxt.cs = cs_hit;
                xaddr_nxt = i_req.addr[`MAD_EXT_AW-1:0];
            end
            default: begin
                wdog_nxt = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Access sequencing
    // ------------------------------------------------------------

    mad_state_t state_r;
    logic [7:0] cnt_r;
    logic ok_r;

    assign take = state_r == MAD_ST_IDLE && i_req_valid;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_r <= MAD_ST_IDLE;
            cnt_r <= 8'h00;
            ok_r <= 1'b0;
        end else begin
            case (state_r)
                MAD_ST_IDLE: begin
                    if (i_req_valid) begin
                        ok_r <= ok_nxt;
                        cnt_r <= 8'h01;
                        state_r <= wdog_nxt ? MAD_ST_WDOG : MAD_ST_ACC;
                    end
                end
                MAD_ST_ACC: begin
                    state_r <= MAD_ST_DONE;
                end
                MAD_ST_WDOG: begin
                    if (cnt_r == `MAD_WDOG_CYC) begin
                        state_r <= MAD_ST_DONE;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                MAD_ST_DONE: begin
                    state_r <= MAD_ST_IDLE;
                end
                default: begin
                    state_r <= MAD_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Target side
    // ------------------------------------------------------------

    mad_sel_t sel_r;
    logic [`MAD_EXT_AW-1:0] xaddr_r;
    logic write_r;
    logic [1:0] size_r;
    logic [31:0] wdata_r;

    // Selects stand for the one ACC cycle, so a write lands exactly once
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sel_r <= '0;
            xaddr_r <= '0;
            write_r <= 1'b0;
            size_r <= 2'h0;
            wdata_r <= 32'h0000_0000;
        end else if (take) begin
            sel_r <= wdog_nxt ? '0 : sel_nxt;
            xaddr_r <= xaddr_nxt;
            write_r <= i_req.write;
            size_r <= i_req.size;
            wdata_r <= i_req.wdata;
        end else begin
            sel_r <= '0;
        end
    end

    logic [31:0] rdata_r;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (state_r == MAD_ST_ACC) begin
            if (write_r || !ok_r) begin
                rdata_r <= 32'h0000_0000;
            end else if (sel_r.per != '0 && i_per_w16) begin
                rdata_r <= {16'h0000, i_tgt_rdata[15:0]};
            end else begin
                rdata_r <= i_tgt_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Termination
    // ------------------------------------------------------------

    logic xack_r;
    logic xerr_r;
    logic err_r;
    logic end_acc;
    logic end_wdog;

    assign end_acc = state_r == MAD_ST_ACC;
    assign end_wdog = state_r == MAD_ST_WDOG && cnt_r == `MAD_WDOG_CYC;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            xack_r <= 1'b0;
            xerr_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            xack_r <= end_acc && ok_r;
            xerr_r <= (end_acc && !ok_r) || end_wdog;
            err_r <= (end_acc && !ok_r) || end_wdog;
        end
    end

    assign o_sel = sel_r;
    assign o_xaddr = xaddr_r;
    assign o_write = write_r;
    assign o_size = size_r;
    assign o_wdata = wdata_r;
    assign o_rdata = rdata_r;
    assign o_transfer_ack = xack_r;
    assign o_transfer_error_ack = xerr_r;
    assign o_access_err = err_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    a_ack_exclusive: assert property (
        !(o_transfer_ack && o_transfer_error_ack))
        else $error("ack and error ack together");

    a_ack_single_pulse: assert property (
        (o_transfer_ack || o_transfer_error_ack) |=> !o_transfer_ack && !o_transfer_error_ack)
        else $error("acknowledge longer than one cycle");

    a_ack_on_time: assert property (
        take && !wdog_nxt |-> ##2 (o_transfer_ack ^ o_transfer_error_ack))
        else $error("normal access not ended two cycles after take");

    a_rom_write_err: assert property (
        take && region == MAD_RG_ROM && i_req.write
        |-> ##2 o_transfer_error_ack && o_access_err)
        else $error("rom write not refused");

    a_rom_read_alias: assert property (
        take && region == MAD_RG_ROM && !i_req.write && !blocked
        |=> o_sel.rom && o_xaddr == {8'h00, $past(i_req.addr[13:0])} ##1 o_transfer_ack)
        else $error("rom read not aliased or acknowledged");

    a_ram_protect: assert property (
        take && region == MAD_RG_RAM && blocked
        |=> !o_sel.ram ##1 o_transfer_error_ack && o_access_err)
        else $error("protected ram access not refused");

    a_ram_alias: assert property (
        take && region == MAD_RG_RAM && !blocked
        |=> o_sel.ram && o_xaddr == {11'h000, $past(i_req.addr[10:0])})
        else $error("ram address not aliased");

    a_per_one_slot: assert property (
        $onehot0(o_sel.per) && !(o_sel.rom && o_sel.ram))
        else $error("more than one target selected");

    a_sel_in_acc: assert property (
        o_sel != '0 |-> state_r == MAD_ST_ACC)
        else $error("target selected outside the access cycle");

    a_per_write_ok: assert property (
        take && per_hit != '0 && i_req.write
        |=> o_sel.per == $past(per_hit) ##1 o_transfer_ack)
        else $error("peripheral write not acknowledged");

    a_per_read_block: assert property (
        take && per_hit != '0 && !i_req.write && blocked
        |=> o_sel.per == '0 ##1 o_transfer_error_ack && o_access_err)
        else $error("protected peripheral read not refused");

    a_per_narrow: assert property (
        end_acc && !write_r && ok_r && sel_r.per != '0 && i_per_w16
        |=> o_rdata[31:16] == 16'h0000)
        else $error("unimplemented bits read non-zero");

    a_ext_wrap: assert property (
        take && region == MAD_RG_EXT
        |=> o_sel.cs[$past(i_req.addr[26:24])] &&
            o_xaddr == $past(i_req.addr[21:0]))
        else $error("external select or wrap wrong");

    a_ext_ack: assert property (
        take && region == MAD_RG_EXT |-> ##2 o_transfer_ack && !o_access_err)
        else $error("external access not acknowledged");

    a_wdog_quiet: assert property (
        state_r == MAD_ST_WDOG |-> !o_transfer_ack && !o_transfer_error_ack && o_sel == '0)
        else $error("reserved access answered early");

    a_wdog_end: assert property (
        take && wdog_nxt
        |=> cnt_r == 8'h01 ##127 end_wdog ##1 o_transfer_error_ack && o_access_err)
        else $error("watchdog did not end access after 128 clocks");

    c_rom_read: cover property (
        take && region == MAD_RG_ROM && !i_req.write ##2 o_transfer_ack);
    c_ext_write: cover property (
        take && region == MAD_RG_EXT && i_req.write ##2 o_transfer_ack);
    c_per_small_slot: cover property (take && per_hit[`MAD_NPER-1] ##2 o_transfer_ack);
    c_wdog_timeout: cover property (end_wdog ##1 o_transfer_error_ack);

endmodule

`default_nettype wire

// File: mad_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module mad_decoder_tb_top
    import mad_pkg::*;
;
    logic clk, srst, prot, w16, vld, wr_o, xack, xerr, aerr;
    logic [31:0] trd, wd_o, rd_o;
    logic [1:0] sz_o;
    logic [21:0] xa, xa_cap;
    mad_req_t req;
    mad_sel_t sel, sel_cap;
    int fails, n_compared, sel_n;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    mad_decoder i_dut (.i_sys_clk(clk), .i_srst(srst), .i_req_valid(vld), .i_req(req),
        .i_sup_prot(prot), .i_tgt_rdata(trd), .i_per_w16(w16), .o_sel(sel),
        .o_xaddr(xa), .o_write(wr_o), .o_size(sz_o), .o_wdata(wd_o), .o_rdata(rd_o),
        .o_transfer_ack(xack), .o_transfer_error_ack(xerr), .o_access_err(aerr));

    mad_core_master i_mst (.i_sys_clk(clk), .i_xfer_ack(xack), .i_xfer_err(xerr),
        .i_access_err(aerr), .o_req_valid(vld), .o_req(req));

    always @(posedge clk) begin
        if (|sel) begin
            sel_n++;
            sel_cap = sel;
            xa_cap = xa;
        end
    end

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic acc(input logic [31:0] a, input logic w, s, p, ok, input int cyc,
                       input mad_sel_t es, input logic [21:0] ex);
        @(negedge clk);
        prot = p;
        sel_n = 0;
        sel_cap = '0;
        // Size varies with the address but stays aligned
        i_mst.access(a, w, s, a[3:2]);
        check("ack", 64'({i_mst.got_ack, i_mst.got_eack, i_mst.got_err}), 64'({ok, !ok, !ok}));
        check("cycles", 64'(i_mst.cyc), 64'(cyc));
        check("select", 64'({sel_cap, 8'(sel_n)}), 64'({es, 8'(|es)}));
        if (|es) check("xfer", 64'({xa_cap, wr_o, sz_o}), 64'({ex, w, a[3:2]}));
        if (|es && w) check("wdata", 64'(wd_o), 64'(a ^ 32'h5A5A_0F0F));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_rom();
        mad_sel_t s;
        s = '0;
        s.rom = 1'b1;
        trd = 32'hC3A5_1E0F;
        acc(32'h000F_C004, 1'b0, 1'b1, 1'b1, 1'b1, 3, s, 22'h0004);
        check("rom_rdata", 64'(rd_o), 64'(trd));
        acc(32'h0000_0010, 1'b0, 1'b0, 1'b1, 1'b0, 3, '0, 22'h0);
        acc(32'h0000_0010, 1'b0, 1'b0, 1'b0, 1'b1, 3, s, 22'h0010);
        acc(32'h0000_0020, 1'b1, 1'b1, 1'b0, 1'b0, 3, '0, 22'h0);
    endtask

    task automatic t_ram();
        mad_sel_t s;
        s = '0;
        s.ram = 1'b1;
        trd = 32'h0F1E_2D3C;
        acc(32'h001F_F808, 1'b0, 1'b1, 1'b1, 1'b1, 3, s, 22'h0008);
        check("ram_rdata", 64'(rd_o), 64'(trd));
        acc(32'h0010_0104, 1'b1, 1'b1, 1'b1, 1'b1, 3, s, 22'h0104);
        acc(32'h0010_0104, 1'b1, 1'b0, 1'b1, 1'b0, 3, '0, 22'h0);
    endtask

    task automatic t_per();
        mad_sel_t s;
        logic [31:0] off;
        trd = 32'hA5A5_5A5A;
        for (int k = 0; k < 16; k++) begin
            s = '0;
            s.per[k] = 1'b1;
            off = (k < 12) ? k * 4096 : 32'hC000 + (k - 12) * 1024;
            w16 = k[0];
            acc(32'h0020_0004 + off, 1'b0, 1'b1, 1'b1, 1'b1, 3, s, 22'(off[11:0] + 4));
            check("per_rdata", 64'(rd_o), 64'(w16 ? 32'h0000_5A5A : trd));
        end
        s = '0;
        s.per[0] = 1'b1;
        acc(32'h0020_0FFC, 1'b1, 1'b0, 1'b1, 1'b1, 3, s, 22'h0FFC);
        acc(32'h0020_1008, 1'b0, 1'b0, 1'b1, 1'b0, 3, '0, 22'h0);
    endtask

    task automatic t_rsv();
        logic [31:0] tbl [6] = '{32'h0020_D000, 32'h003F_FFFC, 32'h0040_0000,
                                  32'h3FFF_FFFC, 32'h4600_0000, 32'hFFFF_FFFC};
        for (int k = 0; k < 6; k++) begin
            acc(tbl[k], k[0], 1'b1, 1'b0, 1'b0, 130, '0, 22'h0);
        end
    endtask

    task automatic t_ext();
        mad_sel_t s;
        for (int c = 0; c < 6; c++) begin
            s = '0;
            s.cs[c] = 1'b1;
            acc(32'h40C0_0010 + (c << 24), c[0], 1'b0, 1'b1, 1'b1, 3, s, 22'h10);
        end
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        fails++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        prot = 1'b0;
        w16 = 1'b0;
        trd = '0;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        check("reset", 64'({xack, xerr, aerr, sel}), 64'h0);
        t_rom();
        t_ram();
        t_per();
        t_rsv();
        t_ext();
        test_done();
    end
endmodule

`default_nettype wire

// File: mad_defines.svh
// Overview of operation
// - ROM region 1 MB at 0000_0000, 16 KB storage aliased across it.
// - ROM reads acknowledge; user mode under supervisor protection gets error and exception.
// - Every ROM write ends in error acknowledge, in any processor mode.
// - RAM region 1 MB at 0010_0000, 2 KB storage aliased across it.
// - RAM reads and writes acknowledge; protected user access gets error and exception.
// - Peripheral window of 2 MB reserved from 0020_0000.
// - Each peripheral answers only inside its own slot.
// - Peripheral registers 16 or 32 bits; unimplemented bits read zero, ignore writes.
// - No misaligned accesses from master; decoder never splits or resizes accesses.
// - Twelve 4 KB peripheral slots then four 1 KB slots; rest reserved.
// - Unassigned reads in first 52 KB acknowledge when supervisor permission allows.
// - Unassigned writes in first 52 KB acknowledge and may alter peripheral registers.
// - Reserved peripheral space: watchdog error and exception after 128 clocks.
// - External region 96 MB at 4000_0000, six 16 MB chip-select windows.
// - Only 22 external address lines, so lowest 4 MB per window addressable.
// - External offsets above 4 MB wrap modulo 4 MB under same select.
// - Other reserved ranges end by watchdog after 128 clocks with error.
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH

`define MAD_ROM_MB 12'h000
`define MAD_RAM_MB 12'h001
`define MAD_PER_2MB 11'h001
`define MAD_EXT_FIRST 8'h40
`define MAD_EXT_NCS 6
`define MAD_ROM_AW 14
`define MAD_RAM_AW 11
`define MAD_EXT_AW 22
`define MAD_PER_AW 12
`define MAD_NPER 16
`define MAD_N4K 12
`define MAD_WDOG_CYC 8'h80

`endif

// File: mad_pkg.sv
`include "mad_defines.svh"

package mad_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic supv;
        logic [1:0] size;
        logic [31:0] wdata;
    } mad_req_t;

    typedef struct packed {
        logic rom;
        logic ram;
        logic [`MAD_NPER-1:0] per;
        logic [`MAD_EXT_NCS-1:0] cs;
    } mad_sel_t;

    typedef enum logic [2:0] {
        MAD_RG_ROM = 3'h0,
        MAD_RG_RAM = 3'h1,
        MAD_RG_PER = 3'h2,
        MAD_RG_EXT = 3'h3,
        MAD_RG_RSV = 3'h4
    } mad_region_t;

    typedef enum logic [3:0] {
        MAD_ST_IDLE = 4'h1,
        MAD_ST_ACC = 4'h2,
        MAD_ST_WDOG = 4'h4,
        MAD_ST_DONE = 4'h8
    } mad_state_t;

endpackage
